// ---- host_mem_model.sv ----
// host memory model taking the link's buffer writes
`timescale 1ns/10ps
`default_nettype none
module host_mem_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wr_valid,
  input  wire logic [31:0] wr_addr,
  input  wire logic [31:0] wr_data,
  output logic             wr_ready,
  output logic             wr_fail,
  input  wire logic [1:0]  delay,
  input  wire logic        fail_one
);
  logic [1:0]  wait_q;
  logic [31:0] addr_q [$];
  logic [31:0] data_q [$];
  // answer delay plus one cycles after the request; the fail line wanders while nobody samples it
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ready <= 1'b0;
      wr_fail  <= 1'b0;
      wait_q   <= 2'h0;
    end else begin
      if (wr_valid && wr_ready && !wr_fail) begin
        addr_q.push_back(wr_addr);
        data_q.push_back(wr_data);
      end
      if (wr_valid && !wr_ready && wait_q == delay) begin
        wr_ready <= 1'b1;
        wr_fail  <= fail_one;
      end else begin
        wr_ready <= 1'b0;
        wr_fail  <= ~wr_fail;
        wait_q   <= (wr_valid && !wr_ready) ? wait_q + 2'h1 : 2'h0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- link_ctl.sv ----
// link control register bank with node identification reception tracking
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "link_ctl_cfg.svh"

module link_ctl
  import link_ctl_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RESET,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic [31:0]      HRDATA,
  input  wire logic        BUS_RESET_SEEN,
  input  wire logic        SID_START,
  input  wire logic        SID_QUAD_VALID,
  input  wire logic [31:0] SID_QUAD_DATA,
  output logic             SID_QUAD_READY,
  input  wire logic        SID_END,
  input  wire logic        SID_HW_FAULT,
  output logic             MEM_WR_VALID,
  output logic [31:0]      MEM_WR_ADDR,
  output logic [31:0]      MEM_WR_DATA,
  input  wire logic        MEM_WR_READY,
  input  wire logic        MEM_WR_FAIL,
  output logic             PHY_LINK_ON,
  output logic             LINK_ACTIVE,
  output logic             POSTED_WRITE_EN,
  output logic             SOFT_RESET_BUSY
);

  regs_t r_q;
  regs_t r_d;

  // offset match on the low address byte; used by both read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // read view of the control bits; reserved positions stay zero
  function automatic logic [31:0] ctl_word(input regs_t r);
    ctl_word = '0;
    ctl_word[`BIT_LPS]  = r.link_power_status_ctl;
    ctl_word[`BIT_PWE]  = r.pwe;
    ctl_word[`BIT_LEN]  = r.len;
    ctl_word[`BIT_SRST] = r.srst;
  endfunction

  // read view of the reception count register
  function automatic logic [31:0] cnt_word(input regs_t r);
    cnt_word = '0;
    cnt_word[`BIT_ERR]               = r.err;
    cnt_word[`GEN_MSB:`GEN_LSB]      = r.gen;
    cnt_word[`QCNT_MSB:`QCNT_LSB]    = r.qcnt;
  endfunction

  logic addr_phase;
  logic quad_take;
  logic wr_done;
  logic link_up;

  // bus handshake and link qualifiers
  assign addr_phase = HSEL && HREADY && HTRANS[1];
  assign link_up    = r_q.link_power_status_ctl && (r_q.st == ST_RUN);
  assign quad_take  = SID_QUAD_VALID && SID_QUAD_READY;
  assign wr_done    = r_q.pend && MEM_WR_READY;

  // next state: bus slave, control bits, reception tracking, soft reset
  always_comb begin
    r_d     = r_q;
    r_d.dwr = 1'b0;
    // address phase: latch target and sample read data for the data phase
    if (addr_phase) begin
      r_d.dwr   = HWRITE;
      r_d.daddr = HADDR[7:0];
      if (!HWRITE) begin
        if (hit(HADDR[7:0], `OFS_CTL_SET) || hit(HADDR[7:0], `OFS_CTL_CLR)) begin
          r_d.rdata = ctl_word(r_q);
        end else if (hit(HADDR[7:0], `OFS_BUF_BASE)) begin
          r_d.rdata = {r_q.base, {`BASE_LSB{1'b0}}};
        end else if (hit(HADDR[7:0], `OFS_RX_COUNT)) begin
          r_d.rdata = cnt_word(r_q);
        end else begin
          r_d.rdata = '0;
        end
      end
    end
    // data phase write: set and clear register pair, base pointer
    if (r_q.dwr && (r_q.st == ST_RUN)) begin
      if (hit(r_q.daddr, `OFS_CTL_SET)) begin
        if (HWDATA[`BIT_LPS]) begin
          r_d.link_power_status_ctl = 1'b1;
        end
        if (HWDATA[`BIT_PWE]) begin
          r_d.pwe = 1'b1;
        end
        if (HWDATA[`BIT_LEN]) begin
          r_d.len = 1'b1;
        end
        if (HWDATA[`BIT_SRST]) begin
          r_d.srst = 1'b1;
          r_d.st   = ST_SRST;
          r_d.scnt = `SRST_CYCLES;
          // drop the control bits at once so a read during the reset shows them clear
          r_d.link_power_status_ctl  = 1'b0;
          r_d.pwe  = 1'b0;
          r_d.len  = 1'b0;
        end
      end else if (hit(r_q.daddr, `OFS_CTL_CLR)) begin
        // the reset bit is not clearable; it ends by itself
        if (HWDATA[`BIT_LPS]) begin
          r_d.link_power_status_ctl = 1'b0;
        end
        if (HWDATA[`BIT_PWE]) begin
          r_d.pwe = 1'b0;
        end
        if (HWDATA[`BIT_LEN]) begin
          r_d.len = 1'b0;
        end
      end else if (hit(r_q.daddr, `OFS_BUF_BASE)) begin
        r_d.base = HWDATA[31:`BASE_LSB];
      end
    end
    // bus reset detection, only while the physical layer is reachable
    if (link_up && BUS_RESET_SEEN) begin
      r_d.gen = r_q.gen + 8'h01;
    end
    // reception tracking
    if (link_up && r_q.len) begin
      if (SID_START) begin
        r_d.rx_act = 1'b1;
        r_d.rx_err = 1'b0;
        r_d.qcnt   = '0;
        r_d.pend   = 1'b0;
      end else if (r_q.rx_act) begin
        // one quadlet in flight; next address follows the count
        if (quad_take) begin
          r_d.pend  = 1'b1;
          r_d.waddr = {r_q.base, r_q.qcnt, 2'h0};
          r_d.wdata = SID_QUAD_DATA;
        end
        if (wr_done) begin
          r_d.pend = 1'b0;
          if (MEM_WR_FAIL || (r_q.qcnt == `QCNT_FULL)) begin
            r_d.rx_err = 1'b1;
            r_d.err    = 1'b1;
          end else begin
            r_d.qcnt = r_q.qcnt + 9'h001;
          end
        end
        if (SID_HW_FAULT) begin
          r_d.rx_err = 1'b1;
          r_d.err    = 1'b1;
        end
        // end of reception: an error seen this very cycle still wins
        if (SID_END) begin
          r_d.rx_act = 1'b0;
          r_d.err    = r_d.rx_err;
        end
      end
    end
    // disconnect at once when the link is not active; next values, so a clear write
    // drops a pending buffer write in the same cycle as the control bit
    if (!r_d.len || !r_d.link_power_status_ctl) begin
      r_d.rx_act = 1'b0;
      r_d.pend   = 1'b0;
    end
    // soft reset: the bus slave fields and the buffer write address and data are kept, all else returns to reset
    if (r_q.st == ST_SRST) begin
      r_d.link_power_status_ctl    = 1'b0;
      r_d.pwe    = 1'b0;
      r_d.len    = 1'b0;
      r_d.base   = '0;
      r_d.err    = 1'b0;
      r_d.gen    = '0;
      r_d.qcnt   = '0;
      r_d.rx_act = 1'b0;
      r_d.rx_err = 1'b0;
      r_d.pend   = 1'b0;
      r_d.scnt   = r_q.scnt - 5'h01;
      if (r_q.scnt == 5'h01) begin
        r_d.st   = ST_RUN;
        r_d.srst = 1'b0;
      end
    end
  end

  // single state register; async reset loads constants only
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      r_q    <= '0;
      r_q.st <= ST_RUN;
    end else begin
      r_q <= r_d;
    end
  end

  // zero wait state slave, always OKAY
  assign HREADYOUT       = 1'b1;
  assign HRESP           = 1'b0;
  assign HRDATA          = r_q.rdata;
  // link side outputs straight from state flops
  assign PHY_LINK_ON     = r_q.link_power_status_ctl && !r_q.srst;
  assign LINK_ACTIVE     = r_q.len;
  assign POSTED_WRITE_EN = r_q.pwe;
  assign SOFT_RESET_BUSY = r_q.srst;
  assign SID_QUAD_READY  = link_up && r_q.len && r_q.rx_act && !r_q.pend;
  assign MEM_WR_VALID    = r_q.pend;
  assign MEM_WR_ADDR     = r_q.waddr;
  assign MEM_WR_DATA     = r_q.wdata;

  // helper: write of the set register carrying a given bit, seen in data phase
  logic set_srst_w;
  logic set_pwe_w;
  assign set_srst_w = r_q.dwr && hit(r_q.daddr, `OFS_CTL_SET) && HWDATA[`BIT_SRST]
                      && (r_q.st == ST_RUN);
  assign set_pwe_w  = r_q.dwr && hit(r_q.daddr, `OFS_CTL_SET) && HWDATA[`BIT_PWE]
                      && (r_q.st == ST_RUN);

  sequence srst_held_s;
    SOFT_RESET_BUSY [*8];
  endsequence

  sequence srst_end_s;
    ##[1:12] !SOFT_RESET_BUSY;
  endsequence

  sequence good_rx_s;
    SID_END && r_q.rx_act && link_up && r_q.len && !r_q.rx_err && !SID_HW_FAULT
    && !(wr_done && (MEM_WR_FAIL || r_q.qcnt == `QCNT_FULL));
  endsequence

  phy_gate_a: assert property (@(posedge CLOCK) disable iff (RESET)
    !r_q.link_power_status_ctl |-> !PHY_LINK_ON)
    else $error("link to phy traffic allowed with power status off");

  pwe_set_a: assert property (@(posedge CLOCK) disable iff (RESET)
    set_pwe_w |=> POSTED_WRITE_EN)
    else $error("posted write enable did not follow set write");

  len_srst_a: assert property (@(posedge CLOCK) disable iff (RESET)
    set_srst_w |=> ##1 !LINK_ACTIVE)
    else $error("link active survived soft reset");

  no_rx_off_a: assert property (@(posedge CLOCK) disable iff (RESET)
    !LINK_ACTIVE |-> !SID_QUAD_READY && !MEM_WR_VALID)
    else $error("reception active while link disabled");

  srst_run_a: assert property (@(posedge CLOCK) disable iff (RESET)
    set_srst_w |=> srst_held_s ##0 srst_end_s)
    else $error("soft reset bit not held or not self cleared");

  err_set_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (SID_HW_FAULT && r_q.rx_act && link_up && r_q.len && !SID_START) |=> r_q.err)
    else $error("error flag not set on hardware fault");

  err_clr_a: assert property (@(posedge CLOCK) disable iff (RESET)
    good_rx_s |=> !r_q.err)
    else $error("error flag not cleared after clean reception");

  gen_step_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (link_up && BUS_RESET_SEEN) |=> r_q.gen == $past(r_q.gen) + 8'h01)
    else $error("generation did not step by one");

  qcnt_start_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (SID_START && link_up && r_q.len) |=> r_q.qcnt == 9'h000)
    else $error("quadlet count not zeroed at start");

  wr_addr_a: assert property (@(posedge CLOCK) disable iff (RESET)
    $rose(MEM_WR_VALID) |-> MEM_WR_ADDR == {r_q.base, r_q.qcnt, 2'h0})
    else $error("write address not base plus count");

  rsvd_zero_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (addr_phase && !HWRITE && hit(HADDR[7:0], `OFS_CTL_SET)) |=>
      HRDATA[15:0] == 16'h0000 && HRDATA[21:20] == 2'h0)
    else $error("reserved control bits read non zero");

  // register bus view: reserved bits, base pointer, slave answers during soft reset
  rsvd_cnt_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (addr_phase && !HWRITE && hit(HADDR[7:0], `OFS_RX_COUNT)) |=>
      HRDATA[30:24] == 7'h00 && HRDATA[15:11] == 5'h00 && HRDATA[1:0] == 2'h0)
    else $error("reserved count bits read non zero");

  base_low_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (addr_phase && !HWRITE && hit(HADDR[7:0], `OFS_BUF_BASE)) |=>
      HRDATA[10:0] == 11'h000)
    else $error("base pointer low bits read non zero");

  base_wr_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (r_q.dwr && (r_q.st == ST_RUN) && hit(r_q.daddr, `OFS_BUF_BASE)) |=>
      r_q.base == $past(HWDATA[31:`BASE_LSB]))
    else $error("base pointer write did not land");

  slave_ok_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (r_q.st == ST_SRST) |-> HREADYOUT && !HRESP)
    else $error("bus slave stalled during soft reset");

  // clear register and soft reset behaviour
  pwe_clr_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (r_q.dwr && (r_q.st == ST_RUN) && hit(r_q.daddr, `OFS_CTL_CLR) && HWDATA[`BIT_PWE])
      |=> !POSTED_WRITE_EN)
    else $error("posted write enable did not follow clear write");

  lps_clr_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (r_q.dwr && (r_q.st == ST_RUN) && hit(r_q.daddr, `OFS_CTL_CLR) && HWDATA[`BIT_LPS])
      |=> !PHY_LINK_ON)
    else $error("phy traffic still allowed after clear write");

  srst_sticky_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (r_q.dwr && hit(r_q.daddr, `OFS_CTL_CLR) && HWDATA[`BIT_SRST] && SOFT_RESET_BUSY
      && r_q.scnt != 5'h01) |=> SOFT_RESET_BUSY)
    else $error("soft reset bit cleared by software");

  srst_clear_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (r_q.st == ST_SRST) |=> !LINK_ACTIVE && !PHY_LINK_ON && !POSTED_WRITE_EN
      && r_q.base == 21'h000000 && r_q.gen == 8'h00 && r_q.qcnt == 9'h000 && !r_q.err)
    else $error("state not returned to reset values during soft reset");

  // generation counter
  gen_hold_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (!BUS_RESET_SEEN && r_q.st == ST_RUN) |=> r_q.gen == $past(r_q.gen))
    else $error("generation moved without a bus reset");

  gen_wrap_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (link_up && BUS_RESET_SEEN && r_q.gen == 8'hFF) |=> r_q.gen == 8'h00)
    else $error("generation did not wrap to zero");

  gen_gate_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (!link_up) |=> r_q.gen == $past(r_q.gen) || r_q.gen == 8'h00)
    else $error("generation counted with the phy unreachable");

  // reception and buffer writes
  qcnt_step_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (wr_done && r_q.rx_act && link_up && r_q.len && !SID_START && !MEM_WR_FAIL
      && r_q.qcnt != `QCNT_FULL) |=> r_q.qcnt == $past(r_q.qcnt) + 9'h001)
    else $error("quadlet count did not step on a good write");

  wr_fail_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (wr_done && r_q.rx_act && link_up && r_q.len && !SID_START && MEM_WR_FAIL)
      |=> r_q.err && r_q.qcnt == $past(r_q.qcnt))
    else $error("failed host write not flagged");

  wr_stand_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (MEM_WR_VALID && !MEM_WR_READY && !SID_START && r_q.st == ST_RUN && !r_q.dwr)
      |=> MEM_WR_VALID && $stable(MEM_WR_ADDR) && $stable(MEM_WR_DATA))
    else $error("buffer write dropped or changed before completion");

  one_flight_a: assert property (@(posedge CLOCK) disable iff (RESET)
    MEM_WR_VALID |-> !SID_QUAD_READY)
    else $error("quadlet accepted while a write pends");

  wr_data_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (quad_take && !SID_START && !r_q.dwr) |=>
      MEM_WR_VALID && MEM_WR_DATA == $past(SID_QUAD_DATA))
    else $error("buffer write data not the taken quadlet");

  err_keep_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (r_q.st == ST_RUN && !r_q.rx_act) |=> r_q.err == $past(r_q.err))
    else $error("error flag moved outside a reception");

  err_end_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (SID_END && r_q.rx_act && link_up && r_q.len && !SID_START && r_q.rx_err)
      |=> r_q.err)
    else $error("error flag cleared after a failed reception");

  start_act_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (SID_START && link_up && r_q.len && !r_q.dwr) |=> r_q.rx_act && !r_q.rx_err)
    else $error("reception did not start cleanly");

  lps_gate_a: assert property (@(posedge CLOCK) disable iff (RESET)
    !r_q.link_power_status_ctl |-> !SID_QUAD_READY)
    else $error("quadlet accepted with power status off");

endmodule
`default_nettype wire

// ---- link_ctl_cfg.svh ----
// constants for the link control and node identification tracking bank
`ifndef LINK_CTL_CFG_SVH
`define LINK_CTL_CFG_SVH
`define OFS_CTL_SET    8'h50
`define OFS_CTL_CLR    8'h54
`define OFS_BUF_BASE   8'h64
`define OFS_RX_COUNT   8'h68
`define BIT_LPS        19
`define BIT_PWE        18
`define BIT_LEN        17
`define BIT_SRST       16
`define BIT_ERR        31
`define GEN_LSB        16
`define GEN_MSB        23
`define QCNT_LSB       2
`define QCNT_MSB       10
`define BASE_LSB       11
`define SRST_CYCLES    5'h10
`define QCNT_FULL      9'h1FF
`endif

// ---- link_ctl_pkg.sv ----
// types for the link control and node identification tracking bank
package link_ctl_pkg;
  typedef enum logic [1:0] {
    ST_RUN  = 2'h1,
    ST_SRST = 2'h2
  } ctl_state_t;

  typedef struct packed {
    ctl_state_t  st;
    logic        link_power_status_ctl;
    logic        pwe;
    logic        len;
    logic        srst;
    logic [4:0]  scnt;
    logic [20:0] base;
    logic        err;
    logic [7:0]  gen;
    logic [8:0]  qcnt;
    logic        rx_act;
    logic        rx_err;
    logic        pend;
    logic [31:0] waddr;
    logic [31:0] wdata;
    logic        dwr;
    logic [7:0]  daddr;
    logic [31:0] rdata;
  } regs_t;
endpackage

// ---- test_link_ctl.sv ----
// testbench for the link control bank and its buffer write path
`timescale 1ns/10ps
`default_nettype none
module test_link_ctl;
  logic        CLOCK = 1'b0;
  logic        RESET = 1'b1;
  logic        HSEL, HWRITE, HREADYOUT, HRESP, fail_one;
  logic [1:0]  HTRANS, mem_delay;
  logic [31:0] HADDR, HWDATA, HRDATA, SID_QUAD_DATA, MEM_WR_ADDR, MEM_WR_DATA, rd;
  logic        BUS_RESET_SEEN, SID_START, SID_QUAD_VALID, SID_QUAD_READY, SID_END;
  logic        SID_HW_FAULT, MEM_WR_VALID, MEM_WR_READY, MEM_WR_FAIL;
  logic        PHY_LINK_ON, LINK_ACTIVE, POSTED_WRITE_EN, SOFT_RESET_BUSY;
  int          mismatches = 0;
  int          check_count = 0;
  int          cycles = 0;

  link_ctl DUT (.CLOCK(CLOCK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA),
    .BUS_RESET_SEEN(BUS_RESET_SEEN), .SID_START(SID_START),
    .SID_QUAD_VALID(SID_QUAD_VALID), .SID_QUAD_DATA(SID_QUAD_DATA),
    .SID_QUAD_READY(SID_QUAD_READY), .SID_END(SID_END), .SID_HW_FAULT(SID_HW_FAULT),
    .MEM_WR_VALID(MEM_WR_VALID), .MEM_WR_ADDR(MEM_WR_ADDR), .MEM_WR_DATA(MEM_WR_DATA),
    .MEM_WR_READY(MEM_WR_READY), .MEM_WR_FAIL(MEM_WR_FAIL), .PHY_LINK_ON(PHY_LINK_ON),
    .LINK_ACTIVE(LINK_ACTIVE), .POSTED_WRITE_EN(POSTED_WRITE_EN),
    .SOFT_RESET_BUSY(SOFT_RESET_BUSY));
  host_mem_model mem (.clk(CLOCK), .rst(RESET), .wr_valid(MEM_WR_VALID),
    .wr_addr(MEM_WR_ADDR), .wr_data(MEM_WR_DATA), .wr_ready(MEM_WR_READY),
    .wr_fail(MEM_WR_FAIL), .delay(mem_delay), .fail_one(fail_one));

  always #2.5 CLOCK = ~CLOCK;

  // cut a hang short; the whole run needs well under 3000 cycles
  always @(posedge CLOCK) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      mismatches = mismatches + 1;
      tally_and_finish();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // one single word transfer; the idle edge on entry keeps reads after writes fresh
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    HSEL   <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= wr;
    HADDR  <= {24'h0, a};
    do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
    HSEL   <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
    #1;
    rd = HRDATA;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check(nm, rd, e);
  endtask

  task automatic bumps(input int n);
    repeat (n) begin
      @(posedge CLOCK);
      BUS_RESET_SEEN <= 1'b1;
      @(posedge CLOCK);
      BUS_RESET_SEEN <= 1'b0;
    end
  endtask

  // a reception of n quadlets; quadlet bad gets a failed write, flt adds a fault
  task automatic rx(input int n, input int bad, input logic flt);
    @(posedge CLOCK);
    SID_START <= 1'b1;
    @(posedge CLOCK);
    SID_START    <= 1'b0;
    SID_HW_FAULT <= flt;
    for (int i = 0; i < n; i++) begin
      fail_one <= (i == bad);
      @(posedge CLOCK);
      SID_HW_FAULT   <= 1'b0;
      SID_QUAD_VALID <= 1'b1;
      SID_QUAD_DATA  <= 32'hA5000000 + i;
      do @(posedge CLOCK); while (SID_QUAD_READY !== 1'b1);
      SID_QUAD_VALID <= 1'b0;
      SID_QUAD_DATA  <= ~(32'hA5000000 + i);
      do @(posedge CLOCK); while (MEM_WR_VALID === 1'b1);
    end
    fail_one <= 1'b0;
    SID_END  <= 1'b1;
    @(posedge CLOCK);
    SID_END <= 1'b0;
  endtask

  initial begin
    {HSEL, HWRITE, HTRANS, HADDR, HWDATA, SID_QUAD_DATA, BUS_RESET_SEEN, SID_START,
     SID_QUAD_VALID, SID_END, SID_HW_FAULT, fail_one} = '0;
    mem_delay = 2'h2;
    repeat (2) @(posedge CLOCK);
    RESET <= 1'b0;
    rchk("ctl", 8'h50, 32'h0);
    rchk("base", 8'h64, 32'h0);
    rchk("count", 8'h68, 32'h0);
    rchk("unmapped", 8'h44, 32'h0);
    xfer(1'b1, 8'h50, 32'hFFFCFFFF); // posted write changed while link idle
    rchk("ctl set", 8'h54, 32'h000C0000);
    check("phy on", PHY_LINK_ON, 1'b1);
    check("posted", POSTED_WRITE_EN, 1'b1);
    xfer(1'b1, 8'h64, 32'hFFFFFFFF);
    rchk("base wr", 8'h64, 32'hFFFFF800);
    xfer(1'b1, 8'h50, 32'h00020000); // link on, then a bus reset
    check("active", LINK_ACTIVE, 1'b1);
    bumps(1);
    rchk("gen 1", 8'h68, 32'h00010000);
    bumps(254);
    rchk("gen 255", 8'h68, 32'h00FF0000);
    bumps(1);
    rchk("gen wrap", 8'h68, 32'h0);
    $display("register and generation tests done");
    rx(3, -1, 1'b0);
    rchk("rx 3", 8'h68, 32'h0000000C);
    for (int i = 0; i < 3; i++) begin
      check("wr addr", mem.addr_q[i], 32'hFFFFF800 + 4 * i);
      check("wr data", mem.data_q[i], 32'hA5000000 + i);
    end
    mem_delay = 2'h0;
    rx(2, 1, 1'b0);
    rchk("rx fail", 8'h68, 32'h80000004);
    rx(1, -1, 1'b1);
    rchk("rx fault", 8'h68, 32'h80000004);
    rx(2, -1, 1'b0);
    rchk("rx clean", 8'h68, 32'h00000008);
    $display("reception tests done");
    xfer(1'b1, 8'h54, 32'h000A0000);
    check("phy off", PHY_LINK_ON, 1'b0);
    SID_START      <= 1'b1;
    SID_QUAD_VALID <= 1'b1;
    repeat (4) @(posedge CLOCK);
    check("rdy off", {SID_QUAD_READY, MEM_WR_VALID}, 32'h0);
    SID_START      <= 1'b0;
    SID_QUAD_VALID <= 1'b0;
    rchk("cnt kept", 8'h68, 32'h00000008);
    xfer(1'b1, 8'h50, 32'h000A0000);
    xfer(1'b1, 8'h50, 32'h00010000);
    rchk("srst busy", 8'h50, 32'h00010000);
    check("busy", SOFT_RESET_BUSY, 1'b1);
    check("resp busy", {HRESP, HREADYOUT}, 32'h1);
    while (SOFT_RESET_BUSY !== 1'b0) @(posedge CLOCK);
    rchk("srst done", 8'h50, 32'h0);
    rchk("srst base", 8'h64, 32'h0);
    rchk("srst cnt", 8'h68, 32'h0);
    $display("soft reset test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
